/* rtl/uart_channel_cfg.svh */
// Purpose: Constants of the single-channel serial controller: offsets, codes, field positions, reset values.
// Assumes: Included by its bare name from every design file that needs it.
// Notes: Definitions only.
// ---------------------------------------------------------------------------
// Overview of operation
// RULE1 - Pull open-drain interrupt low while any unmasked of eight conditions is active.
// RULE2 - Host reads interrupt status register to find the active conditions.
// RULE3 - The reference clock drives the baud generator, counter/timer and other timing.
// RULE4 - Receiver assembles characters least significant bit first.
// RULE5 - Receiver samples on rising edge of external or internal 1x receive clock.
// RULE6 - Transmitter sends characters least significant bit first.
// RULE7 - Serial output stays high while idle, disabled or in local loopback.
// RULE8 - Serial output changes on falling edge of external or internal 1x transmit clock.
// RULE9 - Multi-purpose output shows one of eight functions chosen by output config register.
// RULE10 - Functions: RTS, timer, tx 1x, tx 16x, rx 1x, rx 16x, tx empty, rx ready/full.
// RULE11 - After reset every multi-purpose output carries request-to-send.
// RULE12 - Command codes 8h and 9h assert and negate request-to-send.
// RULE13 - Mode one bit 7 negates request-to-send automatically on tx done or rx full; code also needs mode two bit 5 for tx done.
// RULE14 - Request-to-send normally reflects receiver FIFO not full; code follows codes 8h and 9h alone unless mode one bit 7 is set.
// RULE15 - Input zero level always readable at bit 0 of change and port registers.
// RULE16 - Mode two bit 4 makes input zero an active-low clear-to-send gating transmitter.
// RULE17 - A change-of-state detector records any change on input zero.
// RULE18 - Reset clears status, masks, config, idles channel, stops timer, points at mode one.
// RULE19 - Interrupt output enable drives low while any unmasked condition is active.
// ---------------------------------------------------------------------------
`ifndef UART_CHANNEL_CFG_SVH
`define UART_CHANNEL_CFG_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define REG_MODE 8'h00
`define REG_STATUS 8'h04
`define REG_CLKSEL 8'h08
`define REG_CMD 8'h0c
`define REG_DATA 8'h10
`define REG_INPORT 8'h14
`define REG_INCHG 8'h18
`define REG_ISR 8'h1c
`define REG_IMR 8'h20
`define REG_OUTPUT_PORT_CONFIG 8'h24
`define REG_BAUD 8'h28
`define REG_CTRELOAD 8'h2c
`define REG_CTCTRL 8'h30
`define HSIZE_WORD 3'h2

// ---------------------------------------------------------------------------
// Command codes and fields
// ---------------------------------------------------------------------------
`define CMD_PTR_RESET 4'h1
`define CMD_RX_RESET 4'h2
`define CMD_TX_RESET 4'h3
`define CMD_ERR_RESET 4'h4
`define CMD_RTS_ON 4'h8
`define CMD_RTS_OFF 4'h9
`define EN_ON 2'h1
`define EN_OFF 2'h2
`define MR1_AUTO_RTS 7
`define MR1_FULL_SEL 6
`define MR2_TX_RTS 5
`define MR2_CTS_EN 4
`define LOOP_LOCAL 2'h2
`define CS_TX_EXT 0
`define CS_RX_EXT 1
`define ISR_CT_BIT 5

// ---------------------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------------------
`define OUTPUT_PORT_CONFIG_RESET 3'h0
`define BAUD_RESET 16'h0001
`define FIFO_DEPTH 3'h4
`define BIT_LAST 4'hf
`define RX_MID 4'h7
`define DATA_LAST 3'h7

`endif

/* rtl/uart_channel_pkg.sv */
// Purpose: Types shared by the serial channel modules.
// Assumes: Constants live in uart_channel_cfg.svh.
// Notes: Types only.
package uart_channel_pkg;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP, TX_END} tx_state_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tx_load_s;

  typedef struct packed {
    logic holding_empty;
    logic empty;
    logic line;
  } tx_status_s;

endpackage

/* rtl/sync2.sv */
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage leaves this module.
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      q <= RESET_VAL;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // sync2

/* rtl/uart_tx.sv */
// Purpose: Transmitter with holding register and shifter, one bit per strobe.
// Assumes: strobe marks the falling edge of the selected 1x transmit clock.
// Notes: Fixed 8 data bits, no parity, one stop bit.
`timescale 1ns/10ps
`include "uart_channel_cfg.svh"
module uart_tx
  import uart_channel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire tx_load_s load,
  input wire logic strobe,
  input wire logic enable,
  input wire logic cts_ok,
  input wire logic flush,
  output tx_status_s status,
  output logic done
);
  tx_state_e state_q;
  logic [7:0] hold_q;
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic hold_full_q;
  logic line_q;

  wire at_gap = (state_q == TX_IDLE) || (state_q == TX_END);
  // Clear-to-send is checked only before a character starts, never mid-character
  wire take = strobe & at_gap & hold_full_q & enable & cts_ok; // [RULE16]
  wire accept = load.valid & ~hold_full_q;

  assign done = strobe & (state_q == TX_END) & ~take;
  assign status.holding_empty = ~hold_full_q;
  assign status.empty = (state_q == TX_IDLE) & ~hold_full_q;
  assign status.line = line_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end else if (ce) begin
      if (flush) begin
        hold_full_q <= 1'b0;
      end else if (accept) begin
        hold_q <= load.data;
        hold_full_q <= 1'b1;
      end else if (take) begin
        hold_full_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Shifter
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TX_IDLE;
      line_q <= 1'b1;
      shift_q <= 8'h00;
      bit_q <= 3'h0;
    end else if (ce) begin
      if (flush) begin
        state_q <= TX_IDLE;
        line_q <= 1'b1; // [RULE7]
      end else if (strobe) begin // [RULE8]
        case (state_q)
          TX_IDLE, TX_END: begin
            if (take) begin
              line_q <= 1'b0;
              shift_q <= hold_q;
              bit_q <= 3'h0;
              state_q <= TX_DATA;
            end else begin
              state_q <= TX_IDLE;
            end
          end
          TX_DATA: begin
            line_q <= shift_q[0]; // [RULE6]
            shift_q <= {1'b0, shift_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == `DATA_LAST) begin
              state_q <= TX_STOP;
            end
          end
          TX_STOP: begin
            line_q <= 1'b1;
            state_q <= TX_END;
          end
          default: begin
            state_q <= TX_IDLE;
            line_q <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // uart_tx

/* rtl/uart_channel.sv */
// Purpose: One serial channel with AHB-Lite registers, pin functions and open-drain interrupt.
// Assumes: hclk is the timing reference; pins are asynchronous to it.
// Notes: Fixed 8N1 format; four-deep receive FIFO.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "uart_channel_cfg.svh"
module uart_channel
  import uart_channel_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic multi_purpose_in_zero,
  input wire logic ext_tx_clock,
  input wire logic ext_rx_clock,
  output logic multi_purpose_out,
  output logic irq_request_n,
  output logic irq_request_oe_n
);
  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] mr1_q, mr2_q, imr_q;
  logic ptr_q;
  logic [1:0] clksel_q;
  logic [2:0] output_port_config_q;
  logic [15:0] baud_q, baud_cnt_q, ct_reload_q, ct_cnt_q;
  logic ct_run_q, ct_out_q, ct_flag_q;
  logic rx_en_q, tx_en_q, rts_q, overrun_q, frame_q, delta_q, x16_q;
  logic [3:0] tx_cnt_q, rx_cnt_q;
  logic [3:0] sync_q, prev_q;
  rx_state_e rx_state_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic [7:0] fifo_q [4];
  logic [1:0] wp_q, rp_q;
  logic [2:0] cnt_q;
  tx_status_s tx_stat;
  tx_load_s tx_load;
  logic tx_done;

  wire acc = ce & hsel & htrans[1] & hready & (hsize == `HSIZE_WORD);
  wire rd_acc = acc & ~hwrite;
  wire [7:0] a_addr = haddr[7:0];
  wire [7:0] wd = hwdata[7:0];
  wire [3:0] misc = hwdata[7:4];

  wire wr_mode = wr_pend_q & (wr_addr_q == `REG_MODE);
  wire wr_clk = wr_pend_q & (wr_addr_q == `REG_CLKSEL);
  wire wr_cmd = wr_pend_q & (wr_addr_q == `REG_CMD);
  wire wr_data = wr_pend_q & (wr_addr_q == `REG_DATA);
  wire wr_isr = wr_pend_q & (wr_addr_q == `REG_ISR);
  wire wr_imr = wr_pend_q & (wr_addr_q == `REG_IMR);
  wire wr_output_port_config = wr_pend_q & (wr_addr_q == `REG_OUTPUT_PORT_CONFIG);
  wire wr_baud = wr_pend_q & (wr_addr_q == `REG_BAUD);
  wire wr_ctrl = wr_pend_q & (wr_addr_q == `REG_CTRELOAD);
  wire wr_ctctrl = wr_pend_q & (wr_addr_q == `REG_CTCTRL);

  wire cmd_ptr = wr_cmd & (misc == `CMD_PTR_RESET);
  wire cmd_rxr = wr_cmd & (misc == `CMD_RX_RESET);
  wire cmd_txr = wr_cmd & (misc == `CMD_TX_RESET);
  wire cmd_err = wr_cmd & (misc == `CMD_ERR_RESET);
  wire cmd_rts_on = wr_cmd & (misc == `CMD_RTS_ON);
  wire cmd_rts_off = wr_cmd & (misc == `CMD_RTS_OFF);

  wire rd_mode = rd_acc & (a_addr == `REG_MODE);
  wire rd_data = rd_acc & (a_addr == `REG_DATA);
  wire rd_inchg = rd_acc & (a_addr == `REG_INCHG);

  // ---------------------------------------------------------------------------
  // Status, interrupt and read mux
  // ---------------------------------------------------------------------------
  wire rx_full = (cnt_q == `FIFO_DEPTH);
  wire rx_ready = (cnt_q != 3'h0);
  wire rx_int = mr1_q[`MR1_FULL_SEL] ? rx_full : rx_ready;
  wire [7:0] status_w = {1'b0, frame_q, 1'b0, overrun_q, tx_stat.empty, tx_stat.holding_empty, rx_full, rx_ready};
  wire [7:0] isr_w = {rx_full, frame_q, ct_flag_q, delta_q, overrun_q, tx_stat.empty, rx_int,
                      tx_stat.holding_empty};
  wire [7:0] mode_rd = ptr_q ? mr2_q : mr1_q;
  wire mpi_level = sync_q[1];

  wire [31:0] rd_mux =
    (a_addr == `REG_MODE) ? {24'h000000, mode_rd} :
    (a_addr == `REG_STATUS) ? {24'h000000, status_w} :
    (a_addr == `REG_CLKSEL) ? {30'h00000000, clksel_q} :
    (a_addr == `REG_DATA) ? {24'h000000, fifo_q[rp_q]} :
    (a_addr == `REG_INPORT) ? {31'h00000000, mpi_level} : // [RULE15]
    (a_addr == `REG_INCHG) ? {27'h0000000, delta_q, 3'h0, mpi_level} : // [RULE15]
    (a_addr == `REG_ISR) ? {24'h000000, isr_w} : // [RULE2]
    (a_addr == `REG_IMR) ? {24'h000000, imr_q} :
    (a_addr == `REG_OUTPUT_PORT_CONFIG) ? {29'h00000000, output_port_config_q} :
    (a_addr == `REG_BAUD) ? {16'h0000, baud_q} :
    (a_addr == `REG_CTRELOAD) ? {16'h0000, ct_reload_q} :
    (a_addr == `REG_CTCTRL) ? {31'h00000000, ct_run_q} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      wr_pend_q <= acc & hwrite;
      if (acc) begin
        wr_addr_q <= a_addr;
      end
      if (rd_acc) begin
        hrdata <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mr1_q <= 8'h00;
      mr2_q <= 8'h00;
      ptr_q <= 1'b0; // [RULE18]
      clksel_q <= 2'h0;
      imr_q <= 8'h00; // [RULE18]
      output_port_config_q <= `OUTPUT_PORT_CONFIG_RESET; // [RULE11]
      baud_q <= `BAUD_RESET;
      ct_reload_q <= 16'h0000;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (ce) begin
      if (wr_mode) begin
        if (ptr_q) mr2_q <= wd;
        else mr1_q <= wd;
      end
      // The pointer moves to mode two after any mode register access while it points at mode one; a same-cycle pointer reset wins
      if (cmd_ptr) ptr_q <= 1'b0;
      else if (wr_mode | rd_mode) ptr_q <= 1'b1;
      if (wr_clk) clksel_q <= hwdata[1:0];
      if (wr_imr) imr_q <= wd;
      if (wr_output_port_config) output_port_config_q <= hwdata[2:0]; // [RULE9]
      if (wr_baud) baud_q <= hwdata[15:0];
      if (wr_ctrl) ct_reload_q <= hwdata[15:0];
      if (wr_cmd & (hwdata[1:0] == `EN_ON)) rx_en_q <= 1'b1;
      else if (wr_cmd & (hwdata[1:0] == `EN_OFF)) rx_en_q <= 1'b0;
      if (wr_cmd & (hwdata[3:2] == `EN_ON)) tx_en_q <= 1'b1;
      else if (wr_cmd & (hwdata[3:2] == `EN_OFF)) tx_en_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Baud generator and counter/timer from the reference clock
  // ---------------------------------------------------------------------------
  wire [15:0] baud_last = (baud_q == 16'h0000) ? 16'h0000 : baud_q - 16'h0001;
  wire tick = (baud_cnt_q >= baud_last); // [RULE3]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_cnt_q <= 16'h0000;
      x16_q <= 1'b0;
      tx_cnt_q <= 4'h0;
    end else if (ce) begin
      baud_cnt_q <= tick ? 16'h0000 : baud_cnt_q + 16'h0001; // [RULE3]
      if (tick) begin
        x16_q <= ~x16_q;
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ct_run_q <= 1'b0; // [RULE18]
      ct_cnt_q <= 16'h0000;
      ct_out_q <= 1'b0;
      ct_flag_q <= 1'b0;
    end else if (ce) begin
      if (wr_ctctrl) begin
        ct_run_q <= hwdata[0];
        ct_cnt_q <= ct_reload_q;
      end else if (ct_run_q) begin
        ct_cnt_q <= (ct_cnt_q == 16'h0000) ? ct_reload_q : ct_cnt_q - 16'h0001; // [RULE3]
      end
      if (ct_run_q & ~wr_ctctrl & (ct_cnt_q == 16'h0000)) ct_out_q <= ~ct_out_q;
      // Terminal count beats a same-cycle clear
      if (ct_run_q & ~wr_ctctrl & (ct_cnt_q == 16'h0000)) ct_flag_q <= 1'b1;
      else if (wr_isr & hwdata[`ISR_CT_BIT]) ct_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin synchronisers and edges
  // ---------------------------------------------------------------------------
  sync2 #(.WIDTH(4), .RESET_VAL(4'hf)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .d({ext_rx_clock, ext_tx_clock, multi_purpose_in_zero, serial_in}),
    .q(sync_q)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 4'hf;
    end else if (ce) begin
      prev_q <= sync_q;
    end
  end

  wire ext_rx_rise = sync_q[3] & ~prev_q[3];
  wire ext_tx_fall = ~sync_q[2] & prev_q[2];
  wire mpi_change = sync_q[1] ^ prev_q[1]; // [RULE17]
  wire loopback = (mr2_q[7:6] == `LOOP_LOCAL);
  wire rx_line = loopback ? tx_stat.line : sync_q[0];
  wire rx_ext = clksel_q[`CS_RX_EXT];
  wire tx_ext = clksel_q[`CS_TX_EXT];
  wire tx_1x = tx_ext ? sync_q[2] : tx_cnt_q[3];
  wire rx_1x = rx_ext ? sync_q[3] : rx_cnt_q[3];
  wire tx_strobe = tx_ext ? ext_tx_fall : (tick & (tx_cnt_q == `BIT_LAST)); // [RULE8]
  wire rx_strobe = rx_ext ? ext_rx_rise : (tick & (rx_cnt_q == `RX_MID)); // [RULE5]
  wire rx_start = (rx_state_q == RX_IDLE) & rx_en_q & ~rx_line & (rx_ext | tick);
  wire rx_push = (rx_state_q == RX_STOP) & rx_strobe;

  // ---------------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_q <= RX_IDLE; // [RULE18]
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
    end else if (ce) begin
      // Restart the 1x phase at the start edge so sampling lands mid-bit
      if (rx_start) rx_cnt_q <= 4'h0;
      else if (tick) rx_cnt_q <= rx_cnt_q + 4'h1;
      if (cmd_rxr) begin
        rx_state_q <= RX_IDLE;
      end else begin
        case (rx_state_q)
          RX_IDLE: if (rx_start) rx_state_q <= RX_START;
          RX_START: if (rx_strobe) begin
            rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
            rx_bit_q <= 3'h0;
          end
          RX_DATA: if (rx_strobe) begin // [RULE5]
            rx_sh_q <= {rx_line, rx_sh_q[7:1]}; // [RULE4]
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == `DATA_LAST) rx_state_q <= RX_STOP;
          end
          RX_STOP: if (rx_strobe) rx_state_q <= RX_IDLE;
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  wire push_ok = rx_push & ~rx_full & ~cmd_rxr;
  wire pop = rd_data & rx_ready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      cnt_q <= 3'h0;
    end else if (ce) begin
      if (cmd_rxr) begin
        wp_q <= 2'h0;
        rp_q <= 2'h0;
        cnt_q <= 3'h0;
      end else begin
        if (push_ok) wp_q <= wp_q + 2'h1;
        if (pop) rp_q <= rp_q + 2'h1;
        if (push_ok & ~pop) cnt_q <= cnt_q + 3'h1;
        else if (pop & ~push_ok) cnt_q <= cnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (ce & push_ok) fifo_q[wp_q] <= rx_sh_q;
  end

  // Error and change flags: a same-cycle event wins over its clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_q <= 1'b0; // [RULE18]
      frame_q <= 1'b0;
      delta_q <= 1'b0;
    end else if (ce) begin
      if (rx_push & rx_full) overrun_q <= 1'b1;
      else if (cmd_err) overrun_q <= 1'b0;
      if (rx_push & ~rx_line) frame_q <= 1'b1;
      else if (cmd_err) frame_q <= 1'b0;
      if (mpi_change) delta_q <= 1'b1; // [RULE17]
      else if (rd_inchg) delta_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmitter, request-to-send and pin outputs
  // ---------------------------------------------------------------------------
  assign tx_load.valid = wr_data;
  assign tx_load.data = wd;
  wire cts_ok = ~mr2_q[`MR2_CTS_EN] | ~mpi_level; // [RULE16]

  uart_tx u_tx (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .load(tx_load),
    .strobe(tx_strobe),
    .enable(tx_en_q),
    .cts_ok(cts_ok),
    .flush(cmd_txr),
    .status(tx_stat),
    .done(tx_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_q <= 1'b0;
    end else if (ce) begin
      if (cmd_rts_on) rts_q <= 1'b1; // [RULE12]
      else if (cmd_rts_off) rts_q <= 1'b0; // [RULE12]
      else if (mr1_q[`MR1_AUTO_RTS] & mr2_q[`MR2_TX_RTS] & tx_done) rts_q <= 1'b0; // [RULE13]
    end
  end

  // Receiver hold-off: a full FIFO with a character arriving drops the request
  wire rx_hold_off = rx_full & (rx_state_q != RX_IDLE); // [RULE13]
  wire rts_live = mr1_q[`MR1_AUTO_RTS] ? (rts_q & ~rx_hold_off) : rts_q; // [RULE14]
  wire [7:0] mpo_fn = {rx_int, tx_stat.holding_empty, x16_q, rx_1x, x16_q, tx_1x, ct_out_q, ~rts_live}; // [RULE10]
  wire irq_any = |(isr_w & imr_q); // [RULE1]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out <= 1'b1; // [RULE18]
      multi_purpose_out <= 1'b1;
      irq_request_n <= 1'b0;
      irq_request_oe_n <= 1'b1;
    end else if (ce) begin
      serial_out <= loopback | tx_stat.line; // [RULE7]
      multi_purpose_out <= mpo_fn[output_port_config_q]; // [RULE9]
      irq_request_n <= 1'b0;
      irq_request_oe_n <= ~irq_any; // [RULE19]
    end
  end
endmodule // uart_channel

/* verification/uart_channel_sva.sv */
// Purpose: Port-level checks of the serial channel.
// Assumes: Bench keeps ce high and never sets automatic request-to-send.
// Notes: Bound into every uart_channel instance.
`timescale 1ns/10ps
module uart_channel_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic serial_out,
  input wire logic multi_purpose_in_zero,
  input wire logic multi_purpose_out,
  input wire logic irq_request_n,
  input wire logic irq_request_oe_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_q;
  logic [7:0] a_q;
  logic [2:0] output_port_config_q;
  wire acc = hsel && htrans[1] && hready && hsize == 3'h2 && ce;
  wire cmd_w = wr_q && a_q == 8'h0c && output_port_config_q == 3'h0;
  wire rd_in = acc && !hwrite && (haddr[7:0] == 8'h14 || haddr[7:0] == 8'h18);
  // Shadow of output_port_config: RTS checks need function 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      a_q <= 8'h00;
      output_port_config_q <= 3'h0;
    end else begin
      wr_q <= acc && hwrite;
      a_q <= haddr[7:0];
      if (wr_q && a_q == 8'h24) output_port_config_q <= hwdata[2:0];
    end
  end
  property p_irq_drive; irq_request_n == 1'b0; endproperty
  a_irq_drive: assert property (p_irq_drive) else $error("interrupt data not low");
  property p_tx_rst; $rose(hresetn) |-> serial_out; endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("serial out not marking after reset");
  property p_mpo_rst; $rose(hresetn) |-> multi_purpose_out; endproperty
  a_mpo_rst: assert property (p_mpo_rst) else $error("request to send active after reset");
  property p_irq_rst; $rose(hresetn) |-> irq_request_oe_n; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("interrupt driven after reset");
  property p_start; $fell(serial_out) |-> !serial_out[*8]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  property p_port; rd_in && $past(multi_purpose_in_zero, 6) == multi_purpose_in_zero |=> hrdata[0] == $past(multi_purpose_in_zero); endproperty
  a_port: assert property (p_port) else $error("input level misread");
  property p_rts_on; cmd_w && hwdata[7:4] == 4'h8 |-> ##[1:4] !multi_purpose_out; endproperty
  a_rts_on: assert property (p_rts_on) else $error("request to send not asserted");
  property p_rts_off; cmd_w && hwdata[7:4] == 4'h9 |-> ##[1:4] multi_purpose_out; endproperty
  a_rts_off: assert property (p_rts_off) else $error("request to send not negated");
endmodule // uart_channel_sva
bind uart_channel uart_channel_sva uart_channel_sva_inst (.*);

/* verification/remote_uart.sv */
// Purpose: Remote transceiver on the serial pins, 8N1.
// Assumes: BIT hclk cycles per bit, matching baud divisor 1.
// Notes: Line idles marking; receive samples mid-bit.
`timescale 1ns/10ps
module remote_uart #(parameter int BIT = 16) (
  input wire logic clk,
  input wire logic rx_line,
  output logic tx_line
);
  logic [7:0] got;
  int n_got = 0;
  initial tx_line = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx_line <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  always begin
    @(negedge rx_line);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      got[i] = rx_line;
    end
    n_got++;
  end
endmodule // remote_uart

/* verification/testbench.sv */
// Purpose: Register test of one serial channel.
// Assumes: Baud divisor left at 1, so a bit lasts 16 hclk.
// Notes: ce, hsel, hsize and the external clocks are tied.
`timescale 1ns/10ps
`include "uart_channel_cfg.svh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic mpi0 = 1'b1;
  logic hready, serial_in, serial_out, mpo, oe_n, hresp;
  logic [31:0] hrdata, rdata;
  int n_errors = 0;
  int checks_done = 0;
  always #12.5 hclk = ~hclk;
  uart_channel uart_channel_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(`HSIZE_WORD), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .serial_in(serial_in), .serial_out(serial_out), .multi_purpose_in_zero(mpi0),
    .ext_tx_clock(1'b0), .ext_rx_clock(1'b0), .multi_purpose_out(mpo), .irq_request_n(), .irq_request_oe_n(oe_n));
  remote_uart remote_uart_inst (.clk(hclk), .rx_line(serial_out), .tx_line(serial_in));
  task automatic results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
    if (k == 50) begin n_errors++; results(); end
  endtask
  // Address phase, then IDLE data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rdata = hrdata;
  endtask
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (remote_uart_inst.n_got < n && k < 2000) begin @(posedge hclk); k++; end
    if (k == 2000) begin n_errors++; results(); end
  endtask
  initial begin
    logic [7:0] known = 8'hc1, val = 8'h41;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("serial_out", serial_out, 1);
    chk("mpo", mpo, 1);
    chk("irq_oe", oe_n, 1);
    chk("hresp", hresp, 0);
    bus(1, `REG_CMD, 32'h80);
    repeat (4) @(posedge hclk);
    chk("rts on", mpo, 0);
    bus(1, `REG_CMD, 32'h90);
    repeat (4) @(posedge hclk);
    chk("rts off", mpo, 1);
    for (int i = 0; i < 8; i++) begin
      bus(1, `REG_OUTPUT_PORT_CONFIG, i);
      repeat (4) @(posedge hclk);
      if (known[i]) chk("mpo func", mpo, val[i]);
    end
    bus(1, `REG_OUTPUT_PORT_CONFIG, 0);
    bus(1, `REG_IMR, 1);
    repeat (4) @(posedge hclk);
    chk("irq on", oe_n, 0);
    bus(0, `REG_ISR, 0);
    chk("isr", rdata[0], 1);
    bus(1, `REG_IMR, 0);
    repeat (4) @(posedge hclk);
    chk("irq off", oe_n, 1);
    bus(0, `REG_INCHG, 0);
    mpi0 <= 1'b0;
    repeat (8) @(posedge hclk);
    bus(0, `REG_INCHG, 0);
    chk("inchg", rdata, 32'h10);
    bus(0, `REG_INPORT, 0);
    chk("inport", rdata, 0);
    bus(0, `REG_INCHG, 0);
    chk("inchg clr", rdata, 0);
    bus(1, `REG_CMD, 32'h04);
    bus(1, `REG_MODE, 0);
    bus(1, `REG_MODE, 32'h10);
    bus(1, `REG_DATA, 32'ha5);
    wait_got(1);
    chk("tx char", remote_uart_inst.got, 32'ha5);
    mpi0 <= 1'b1;
    repeat (8) @(posedge hclk);
    bus(1, `REG_DATA, 32'h3c);
    repeat (400) @(posedge hclk);
    chk("cts hold", remote_uart_inst.n_got, 1);
    chk("idle line", serial_out, 1);
    mpi0 <= 1'b0;
    wait_got(2);
    chk("cts char", remote_uart_inst.got, 32'h3c);
    bus(1, `REG_CMD, 32'h01);
    remote_uart_inst.send(8'h96);
    repeat (40) @(posedge hclk);
    bus(0, `REG_STATUS, 0);
    chk("rx ready", rdata[0], 1);
    bus(0, `REG_DATA, 0);
    chk("rx char", rdata, 32'h96);
    // Local loopback
    bus(1, `REG_MODE, 32'h90);
    bus(1, `REG_DATA, 32'h55);
    repeat (300) @(posedge hclk);
    chk("loop line", remote_uart_inst.n_got, 2);
    bus(0, `REG_DATA, 0);
    chk("loop char", rdata, 32'h55);
    results();
  end
endmodule // testbench
